// [logic/ppmc_consts.svh]
// Constants of the PHY power and mode control block
`ifndef PPMC_CONSTS_SVH
`define PPMC_CONSTS_SVH

`define PPMC_DW 16
`define PPMC_AW 8
`define PPMC_IW 6

`define PPMC_IDX_CTRL   6'h00
`define PPMC_IDX_STAT   6'h01
`define PPMC_IDX_ABIL   6'h04
`define PPMC_IDX_ERRMAX 6'h12
`define PPMC_IDX_EXT2   6'h13

`define PPMC_CTRL_SWRST  15
`define PPMC_CTRL_SPEED  13
`define PPMC_CTRL_ANEN   12
`define PPMC_CTRL_PDOWN  11
`define PPMC_CTRL_DUPLEX 8

`define PPMC_STAT_ANDONE 5
`define PPMC_STAT_RFAULT 4
`define PPMC_STAT_LINK   2
`define PPMC_STAT_JABBER 1

`define PPMC_ABIL_LSB 5
`define PPMC_ABIL_MSB 8

`define PPMC_EXT2_SAVE100 0
`define PPMC_EXT2_SAVE10  1

`define PPMC_CTRL_RST   16'h3100
`define PPMC_STAT_RST   16'h0000
`define PPMC_ABIL_RST   16'h01E1
`define PPMC_EXT2_RST   16'h0000
`define PPMC_ERRMAX_RST 8'h00
`define PPMC_SCR_SEED   11'h7FF

`define PPMC_CLK_NS 20
`define PPMC_SQE_NS 1000
`define PPMC_SQE_CYC ((`PPMC_SQE_NS + `PPMC_CLK_NS - 1) / `PPMC_CLK_NS)

`endif

// [logic/ppmc_pkg.sv]
// Types of the PHY power and mode control block
`include "ppmc_consts.svh"

package ppmc_pkg;

   typedef struct packed {
      logic       hwResetLowPin;
      logic       macTxEn;
      logic [3:0] macTxData;
      logic       lineRxDv;
      logic [4:0] lineRxSym;
      logic [7:0] lineRxMan;
      logic       lineLinkUp;
      logic       lineJabber;
      logic       lineRemoteFault;
      logic       lineRxErr;
      logic [3:0] partnerAbility;
   } ppmc_pin_type;

   typedef struct packed {
      logic [`PPMC_DW-1:0] ctrl;
      logic [`PPMC_DW-1:0] stat;
      logic [`PPMC_DW-1:0] abil;
      logic [`PPMC_DW-1:0] ext2;
      logic [7:0]          errMax;
      logic [`PPMC_DW-1:0] rdata;
      logic                speed100;
      logic                fullDuplex;
      logic                en100;
      logic                en10;
      logic                crs;
      logic                col;
      logic                rxDv;
      logic [3:0]          rxData;
      logic [4:0]          tx100Code;
      logic [7:0]          tx10Code;
      logic [1:0]          tpTxOut;
      logic                tpTxOe;
      logic [1:0]          mltPhase;
      logic                nrziLevel;
      logic [10:0]         scr;
      logic [10:0]         dscr;
      logic [5:0]          sqeCnt;
      logic                txEnLast;
   } ppmc_state_type;

endpackage

// [logic/ppmc_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps

module ppmc_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= RST_VAL;
         dout   <= RST_VAL;
      end else if (ce) begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule

// [logic/ppmc_top.sv]
// PHY power-down, power-saving, mode and duplex control
//
// Behaviour
// - Power down on reset pin low or bit
// - Power down: functions off, MAC outputs low
// - Power down: transmit pair in high impedance
// - Bit power-down keeps registers, clears latching bits
// - Reset power-down returns all registers to defaults
// - Save bit disables 100M modules in 10M
// - Save bit disables 10M modules in 100M
// - Control bit enables or disables auto-negotiation
// - Auto-negotiation picks highest common mode
// - 100M: 4B/5B, NRZI, MLT-3 and scrambling
// - 10M: Manchester encode and decode
// - Full duplex: transmit and receive concurrently
// - 10M full duplex: no loopback, no SQE
// - Full duplex: CRS receive only, COL off
// - Half duplex: CRS either way, COL on overlap
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "ppmc_consts.svh"

module ppmc_top (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                ce,
   input  wire logic [`PPMC_AW-1:0] addr,
   input  wire logic [`PPMC_DW-1:0] wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic      [`PPMC_DW-1:0] rdata,
   input  wire logic                hwResetLowPin,
   input  wire logic                macTxEn,
   input  wire logic [3:0]          macTxData,
   input  wire logic                lineRxDv,
   input  wire logic [4:0]          lineRxSym,
   input  wire logic [7:0]          lineRxMan,
   input  wire logic                lineLinkUp,
   input  wire logic                lineJabber,
   input  wire logic                lineRemoteFault,
   input  wire logic                lineRxErr,
   input  wire logic [3:0]          partnerAbility,
   output logic                     macCrs,
   output logic                     macCol,
   output logic                     macRxDv,
   output logic      [3:0]          macRxData,
   output logic      [4:0]          tx100Code,
   output logic      [7:0]          tx10Code,
   output logic      [1:0]          tpTxOut,
   output logic                     tpTxOe,
   output logic                     en100Modules,
   output logic                     en10Modules,
   output logic                     speed100,
   output logic                     fullDuplex,
   output logic                     powerDown
);

   localparam logic [5:0] SQE_CYC = 6'(`PPMC_SQE_CYC);

   ////////////////////////////////////////////////////////////////////////////////

   function automatic logic [4:0] enc4b5b(input logic [3:0] nib);
      logic [4:0] c;
      c = 5'h00;
      unique case (nib)
         4'h0: c = 5'h1E;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0A;
         4'h5: c = 5'h0B;
         4'h6: c = 5'h0E;
         4'h7: c = 5'h0F;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'hA: c = 5'h16;
         4'hB: c = 5'h17;
         4'hC: c = 5'h1A;
         4'hD: c = 5'h1B;
         4'hE: c = 5'h1C;
         4'hF: c = 5'h1D;
      endcase
      return c;
   endfunction

   function automatic logic [3:0] dec5b4b(input logic [4:0] sym);
      logic [3:0] n;
      n = 4'h0;
      // Invalid symbols decode as zero; error flagging lives in the line logic
      case (sym)
         5'h1E: n = 4'h0;
         5'h09: n = 4'h1;
         5'h14: n = 4'h2;
         5'h15: n = 4'h3;
         5'h0A: n = 4'h4;
         5'h0B: n = 4'h5;
         5'h0E: n = 4'h6;
         5'h0F: n = 4'h7;
         5'h12: n = 4'h8;
         5'h13: n = 4'h9;
         5'h16: n = 4'hA;
         5'h17: n = 4'hB;
         5'h1A: n = 4'hC;
         5'h1B: n = 4'hD;
         5'h1C: n = 4'hE;
         5'h1D: n = 4'hF;
         default: n = 4'h0;
      endcase
      return n;
   endfunction

   // Five scrambler steps: key in the top bits, new state below
   function automatic logic [15:0] scrStep(input logic [10:0] st);
      logic [10:0] v;
      logic [4:0]  k;
      v = st;
      k = 5'h00;
      for (int i = 4; i >= 0; i--) begin
         k[i] = v[10] ^ v[8];
         v    = {v[9:0], v[10] ^ v[8]};
      end
      return {k, v};
   endfunction

   function automatic logic [7:0] manEnc(input logic [3:0] nib);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 4; i++) begin
         m[2*i]   = nib[i];
         m[2*i+1] = ~nib[i];
      end
      return m;
   endfunction

   function automatic logic [3:0] manDec(input logic [7:0] m);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 4; i++) begin
         n[i] = m[2*i];
      end
      return n;
   endfunction

   function automatic ppmc_pkg::ppmc_state_type resetState();
      ppmc_pkg::ppmc_state_type r;
      r        = '0;
      r.ctrl   = `PPMC_CTRL_RST;
      r.stat   = `PPMC_STAT_RST;
      r.abil   = `PPMC_ABIL_RST;
      r.ext2   = `PPMC_EXT2_RST;
      r.errMax = `PPMC_ERRMAX_RST;
      r.scr    = `PPMC_SCR_SEED;
      r.dscr   = `PPMC_SCR_SEED;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////

   ppmc_pkg::ppmc_pin_type   pinRaw;
   ppmc_pkg::ppmc_pin_type   pin;
   ppmc_pkg::ppmc_state_type state;
   ppmc_pkg::ppmc_state_type next_state;

   assign pinRaw = '{hwResetLowPin, macTxEn, macTxData, lineRxDv, lineRxSym, lineRxMan,
                     lineLinkUp, lineJabber, lineRemoteFault, lineRxErr, partnerAbility};

   // Synced reset pin starts low, so registers sit at defaults until released
   ppmc_sync #(
      .WIDTH   ($bits(ppmc_pkg::ppmc_pin_type)),
      .RST_VAL ('0)
   ) u_sync (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .din  (pinRaw),
      .dout (pin)
   );

   ////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      logic                pinReset;
      logic                pd;
      logic                hit;
      logic [`PPMC_IW-1:0] idx;
      logic                statRead;
      logic [3:0]          common;
      logic [15:0]         sv;
      logic [4:0]          sc;
      logic                halfTen;
      next_state = state;
      pinReset   = ~pin.hwResetLowPin;
      hit        = (addr[1:0] == 2'b00);
      idx        = addr[`PPMC_AW-1:2];
      statRead   = rd && hit && (idx == `PPMC_IDX_STAT);
      common     = state.abil[`PPMC_ABIL_MSB:`PPMC_ABIL_LSB] & pin.partnerAbility;
      sv         = 16'h0000;
      sc         = 5'h00;
      halfTen    = ~state.speed100 & ~state.fullDuplex;
      // clearing the bit alone resumes operation
      pd         = pinReset | state.ctrl[`PPMC_CTRL_PDOWN];

      // Read data valid only in the cycle after the strobe
      next_state.rdata = 16'h0000;
      if (rd && hit) begin
         unique case (idx)
            `PPMC_IDX_CTRL:   next_state.rdata = state.ctrl;
            `PPMC_IDX_STAT:   next_state.rdata = state.stat;
            `PPMC_IDX_ABIL:   next_state.rdata = state.abil;
            `PPMC_IDX_ERRMAX: next_state.rdata = {8'h00, state.errMax};
            `PPMC_IDX_EXT2:   next_state.rdata = state.ext2;
            default:          next_state.rdata = 16'h0000;
         endcase
      end
      if (wr && hit) begin
         unique case (idx)
            `PPMC_IDX_CTRL: next_state.ctrl = wdata;
            `PPMC_IDX_ABIL: next_state.abil = wdata;
            `PPMC_IDX_EXT2: next_state.ext2 = wdata;
            default:        next_state.ctrl = state.ctrl;
         endcase
      end

      // Latching status: events win over the clear on read
      if (statRead) begin
         next_state.stat[`PPMC_STAT_JABBER] = 1'b0;
         next_state.stat[`PPMC_STAT_RFAULT] = 1'b0;
         next_state.stat[`PPMC_STAT_LINK]   = pin.lineLinkUp;
      end
      if (pin.lineJabber) begin
         next_state.stat[`PPMC_STAT_JABBER] = 1'b1;
      end
      if (pin.lineRemoteFault) begin
         next_state.stat[`PPMC_STAT_RFAULT] = 1'b1;
      end
      if (!pin.lineLinkUp) begin
         next_state.stat[`PPMC_STAT_LINK] = 1'b0;
      end
      if (rd && hit && (idx == `PPMC_IDX_ERRMAX)) begin
         next_state.errMax = 8'h00;
      end
      if (pin.lineRxErr && (next_state.errMax != 8'hFF)) begin
         next_state.errMax = 8'(next_state.errMax + 8'h01);
      end

      // auto-negotiation enable bit steers mode selection
      if (!pd) begin
         if (state.ctrl[`PPMC_CTRL_ANEN]) begin
            next_state.speed100   = common[3] | common[2];
            next_state.fullDuplex = common[3] | (~common[2] & common[1]);
         end else begin
            next_state.speed100   = state.ctrl[`PPMC_CTRL_SPEED];
            next_state.fullDuplex = state.ctrl[`PPMC_CTRL_DUPLEX];
         end
      end
      next_state.stat[`PPMC_STAT_ANDONE] = state.ctrl[`PPMC_CTRL_ANEN] & pin.lineLinkUp
                                           & (|common);

      // 100M power save in 10M mode
      next_state.en100 = ~pd & (state.speed100 | ~state.ext2[`PPMC_EXT2_SAVE100]);
      // 10M power save in 100M mode
      next_state.en10  = ~pd & (~state.speed100 | ~state.ext2[`PPMC_EXT2_SAVE10]);

      // transmit and receive paths run independently
      next_state.tx100Code = 5'h00;
      next_state.tx10Code  = 8'h00;
      next_state.tpTxOut   = 2'b00;
      if (state.speed100 && state.en100 && pin.macTxEn) begin
         sv = scrStep(state.scr);
         sc = enc4b5b(pin.macTxData) ^ sv[15:11];
         next_state.scr = sv[10:0];
         for (int i = 4; i >= 0; i--) begin
            next_state.nrziLevel    = next_state.nrziLevel ^ sc[i];
            next_state.tx100Code[i] = next_state.nrziLevel;
            if (sc[i]) begin
               next_state.mltPhase = 2'(next_state.mltPhase + 2'h1);
            end
         end
      end
      if (state.speed100 && state.en100) begin
         next_state.tpTxOut = (next_state.mltPhase == 2'h1) ? 2'b10 :
                              (next_state.mltPhase == 2'h3) ? 2'b01 : 2'b00;
      end
      if (!state.speed100 && state.en10 && pin.macTxEn) begin
         next_state.tx10Code = manEnc(pin.macTxData);
         next_state.tpTxOut  = {next_state.tx10Code[7], ~next_state.tx10Code[7]};
      end

      next_state.rxDv   = pin.lineRxDv;
      next_state.rxData = 4'h0;
      if (state.speed100 && state.en100 && pin.lineRxDv) begin
         sv = scrStep(state.dscr);
         next_state.dscr   = sv[10:0];
         next_state.rxData = dec5b4b(pin.lineRxSym ^ sv[15:11]);
      end
      if (!state.speed100 && state.en10 && pin.lineRxDv) begin
         next_state.rxData = manDec(pin.lineRxMan);
      end

      // loopback only in 10M half duplex
      if (halfTen && pin.macTxEn && !pin.lineRxDv) begin
         next_state.rxData = pin.macTxData;
      end
      next_state.txEnLast = pin.macTxEn;
      // SQE test pulse only in 10M half duplex
      if (state.sqeCnt != 6'h00) begin
         next_state.sqeCnt = 6'(state.sqeCnt - 6'h01);
      end
      if (halfTen && state.txEnLast && !pin.macTxEn) begin
         next_state.sqeCnt = SQE_CYC;
      end
      if (state.fullDuplex) begin
         next_state.crs    = pin.lineRxDv;
         next_state.col    = 1'b0;
         next_state.sqeCnt = 6'h00;
      end else begin
         next_state.crs = pin.lineRxDv | pin.macTxEn;
         next_state.col = (pin.lineRxDv & pin.macTxEn) | (next_state.sqeCnt != 6'h00);
      end
      next_state.tpTxOe = 1'b1;

      if (pd) begin
         // internal functions idle, MAC outputs low
         next_state.en100     = 1'b0;
         next_state.en10      = 1'b0;
         next_state.crs       = 1'b0;
         next_state.col       = 1'b0;
         next_state.rxDv      = 1'b0;
         next_state.rxData    = 4'h0;
         next_state.tx100Code = 5'h00;
         next_state.tx10Code  = 8'h00;
         next_state.sqeCnt    = 6'h00;
         next_state.mltPhase  = 2'h0;
         next_state.nrziLevel = 1'b0;
         next_state.scr       = `PPMC_SCR_SEED;
         next_state.dscr      = `PPMC_SCR_SEED;
         next_state.tpTxOut   = 2'b00;
         next_state.tpTxOe    = 1'b0;
      end
      if (state.ctrl[`PPMC_CTRL_PDOWN]) begin
         // latching bits back to defaults, rest kept
         next_state.stat[`PPMC_STAT_JABBER] = 1'(`PPMC_STAT_RST >> `PPMC_STAT_JABBER);
         next_state.stat[`PPMC_STAT_RFAULT] = 1'(`PPMC_STAT_RST >> `PPMC_STAT_RFAULT);
         next_state.stat[`PPMC_STAT_LINK]   = 1'(`PPMC_STAT_RST >> `PPMC_STAT_LINK);
         next_state.errMax                  = `PPMC_ERRMAX_RST;
      end
      if (pinReset || state.ctrl[`PPMC_CTRL_SWRST]) begin
         next_state.ctrl   = `PPMC_CTRL_RST;
         next_state.stat   = `PPMC_STAT_RST;
         next_state.abil   = `PPMC_ABIL_RST;
         next_state.ext2   = `PPMC_EXT2_RST;
         next_state.errMax = `PPMC_ERRMAX_RST;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= resetState();
      end else if (ce) begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   // Registered power-down view; pin path lags two sync stages
   assign powerDown    = ~state.tpTxOe;
   assign rdata        = state.rdata;
   assign macCrs       = state.crs;
   assign macCol       = state.col;
   assign macRxDv      = state.rxDv;
   assign macRxData    = state.rxData;
   assign tx100Code    = state.tx100Code;
   assign tx10Code     = state.tx10Code;
   assign tpTxOut      = state.tpTxOut;
   assign tpTxOe       = state.tpTxOe;
   assign en100Modules = state.en100;
   assign en10Modules  = state.en10;
   assign speed100     = state.speed100;
   assign fullDuplex   = state.fullDuplex;

endmodule

// [dv/ppmc_top_assertions.sv]
// Port checks for the power and mode control block
`timescale 1ns/1ps
//////////////////////////////////////////////////
module ppmc_top_chk (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       hwResetLowPin,
   input wire logic       macTxEn,
   input wire logic       lineRxDv,
   input wire logic       macCrs,
   input wire logic       macCol,
   input wire logic       macRxDv,
   input wire logic [3:0] macRxData,
   input wire logic       tpTxOe,
   input wire logic       en100Modules,
   input wire logic       en10Modules,
   input wire logic       speed100,
   input wire logic       fullDuplex,
   input wire logic       powerDown
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Pins lag three edges: two sync stages and the output flop
   sequence pdHeld;
      powerDown [*3];
   endsequence
   sequence txDone;
      macTxEn ##1 !macTxEn;
   endsequence
   sequence halfRun;
      !fullDuplex && !$past(fullDuplex, 3) && !powerDown && !$past(powerDown, 3);
   endsequence
   sequence fullRun;
      fullDuplex && $past(fullDuplex, 3) && !powerDown && !$past(powerDown, 3);
   endsequence
   chk_pin_pdown: assert property (!hwResetLowPin [*4] |-> powerDown && !tpTxOe)
      else $error("no power-down with reset pin low");
   chk_pd_quiet: assert property (pdHeld |->
      !macCrs && !macCol && !macRxDv && macRxData == 4'h0) else $error("MAC outputs live");
   chk_pd_mods: assert property (pdHeld |-> !en100Modules && !en10Modules)
      else $error("modules enabled in power-down");
   chk_run_100: assert property ((speed100 && !powerDown) [*3] |-> en100Modules)
      else $error("100M modules off in 100M mode");
   chk_run_10: assert property ((!speed100 && !powerDown) [*3] |-> en10Modules)
      else $error("10M modules off in 10M mode");
   chk_fd_crs: assert property (fullRun |-> macCrs == $past(lineRxDv, 3) && !macCol)
      else $error("full duplex carrier or collision wrong");
   chk_hd_crs: assert property (halfRun |->
      macCrs == ($past(macTxEn, 3) || $past(lineRxDv, 3)))
      else $error("half duplex carrier wrong");
   chk_hd_col: assert property (halfRun ##0 ($past(macTxEn, 3) && $past(lineRxDv, 3))
      |-> macCol) else $error("collision missing");
   chk_fd_nosqe: assert property (txDone ##1 (fullDuplex && !speed100 && !powerDown) [*5]
      |-> !macCol) else $error("heartbeat in full duplex");
endmodule

bind ppmc_top ppmc_top_chk u_chk (.clk, .rst, .hwResetLowPin, .macTxEn, .lineRxDv, .macCrs,
   .macCol, .macRxDv, .macRxData, .tpTxOe, .en100Modules, .en10Modules, .speed100,
   .fullDuplex, .powerDown);

// [dv/ppmc_mac_model.sv]
// Behavioural MAC and line partner for transmit and receive traffic
`timescale 1ns/1ps
//////////////////////////////////////////////////
module ppmc_mac_model (
   input  wire logic       clk,
   input  wire logic       txReq,
   input  wire logic       rxReq,
   output logic            macTxEn = 1'b0,
   output logic      [3:0] macTxData = 4'h0,
   output logic            lineRxDv = 1'b0,
   output logic      [4:0] lineRxSym = 5'h00,
   output logic      [7:0] lineRxMan = 8'h00
);
   logic [3:0] cnt = 4'h0;
   // Data keeps changing when idle, so stale nibbles never look valid
   always @(posedge clk) begin
      cnt <= cnt + 4'h1;
      macTxEn <= txReq;
      macTxData <= cnt;
      lineRxDv <= rxReq;
      lineRxSym <= {1'b1, ~cnt};
      lineRxMan <= {~cnt[3], cnt[3], ~cnt[2], cnt[2], ~cnt[1], cnt[1], ~cnt[0], cnt[0]};
   end
endmodule

// [dv/phy_power_mode_control_tb.sv]
// Self-checking bench for the power and mode control block
`timescale 1ns/1ps
`include "ppmc_consts.svh"
//////////////////////////////////////////////////
module phy_power_mode_control_tb;
   localparam logic [7:0]  addrCtrl = {`PPMC_IDX_CTRL, 2'b00};
   localparam logic [7:0]  addrAbil = {`PPMC_IDX_ABIL, 2'b00};
   localparam logic [7:0]  addrStat = {`PPMC_IDX_STAT, 2'b00};
   localparam logic [7:0]  addrErr  = {`PPMC_IDX_ERRMAX, 2'b00};
   localparam logic [7:0]  addrExt2 = {`PPMC_IDX_EXT2, 2'b00};
   localparam logic [15:0] pdBit    = 16'h0001 << `PPMC_CTRL_PDOWN;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic [`PPMC_AW-1:0] addr = 8'h00;
   logic [`PPMC_DW-1:0] wdata = 16'h0000;
   logic                wr = 1'b0;
   logic                rd = 1'b0;
   logic                hwResetLowPin = 1'b1;
   logic                lineRxErr = 1'b0;
   logic                lineJabber = 1'b0;
   logic [3:0]          partnerAbility = 4'hF;
   logic                txReq = 1'b0;
   logic                rxReq = 1'b0;
   logic [`PPMC_DW-1:0] rdata;
   logic [7:0]          tx10Code, lineRxMan;
   logic [4:0]          lineRxSym, tx100Code;
   logic [3:0]          macTxData, macRxData;
   logic [1:0]          tpTxOut;
   logic                macTxEn, lineRxDv, macCrs, macCol, macRxDv, tpTxOe;
   logic                en100Modules, en10Modules, speed100, fullDuplex, powerDown;
   int                  errTotal = 0;
   int                  testsRun = 0;

   ppmc_mac_model u_mac (.clk, .txReq, .rxReq, .macTxEn, .macTxData, .lineRxDv, .lineRxSym,
      .lineRxMan);
   ppmc_top u_dut (.clk, .rst, .ce(1'b1), .addr, .wdata, .wr, .rd, .rdata, .hwResetLowPin,
      .macTxEn, .macTxData, .lineRxDv, .lineRxSym, .lineRxMan, .lineLinkUp(1'b1),
      .lineJabber, .lineRemoteFault(1'b0), .lineRxErr, .partnerAbility, .macCrs,
      .macCol, .macRxDv, .macRxData, .tx100Code, .tx10Code, .tpTxOut, .tpTxOe,
      .en100Modules, .en10Modules, .speed100, .fullDuplex, .powerDown);

   always #10 clk = ~clk;
   //////////////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      testsRun++;
      if (got !== exp) begin
         errTotal++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask
   task automatic traffic(input logic t, input logic r);
      @(posedge clk);
      txReq <= t;
      rxReq <= r;
      waitc(6);
   endtask
   task automatic errBurst(input int n);
      @(posedge clk);
      lineRxErr <= 1'b1;
      lineJabber <= 1'b1;
      repeat (n) @(posedge clk);
      lineRxErr <= 1'b0;
      lineJabber <= 1'b0;
   endtask
   task automatic printVerdict;
      if (errTotal == 0 && testsRun > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////
   task automatic runDefaults;
      check(powerDown, 1'b0);
      check(tpTxOe, 1'b1);
      rdChk(addrCtrl, `PPMC_CTRL_RST);
      rdChk(addrAbil, `PPMC_ABIL_RST);
      rdChk(addrExt2, `PPMC_EXT2_RST);
      rdChk(8'h08, 16'h0000);
      check({speed100, fullDuplex}, 2'b11);
   endtask
   task automatic runBitPowerDown;
      wrReg(addrExt2, 16'h0003);
      errBurst(3);
      waitc(4);
      rdChk(addrErr, 16'h0003);
      rdChk(addrStat, 16'h0022);
      // Fresh errors just before entry must still be wiped
      errBurst(2);
      wrReg(addrCtrl, `PPMC_CTRL_RST | pdBit);
      traffic(1'b1, 1'b1);
      check(powerDown, 1'b1);
      check(tpTxOe, 1'b0);
      check({macCrs, macCol, macRxDv}, 3'h0);
      check({macRxData, tx10Code}, 12'h000);
      check({tpTxOut, tx100Code}, 7'h00);
      rdChk(addrCtrl, `PPMC_CTRL_RST | pdBit);
      rdChk(addrExt2, 16'h0003);
      rdChk(addrErr, 16'h0000);
      rdChk(addrStat, 16'h0020);
      wrReg(addrCtrl, `PPMC_CTRL_RST);
      waitc(6);
      check({powerDown, tpTxOe, macCrs}, 3'h3);
      rdChk(addrExt2, 16'h0003);
      traffic(1'b0, 1'b0);
   endtask
   task automatic runPinReset;
      wrReg(addrCtrl, 16'h0100);
      @(posedge clk);
      hwResetLowPin <= 1'b0;
      waitc(5);
      check({powerDown, tpTxOe}, 2'h2);
      @(posedge clk);
      hwResetLowPin <= 1'b1;
      waitc(6);
      rdChk(addrExt2, `PPMC_EXT2_RST);
      rdChk(addrCtrl, `PPMC_CTRL_RST);
   endtask
   task automatic runSave;
      for (int i = 0; i < 8; i++) begin
         wrReg(addrCtrl, i[2] ? 16'h2100 : 16'h0100);
         wrReg(addrExt2, {14'h0000, i[1:0]});
         waitc(3);
         check(en100Modules, !(!i[2] && i[0]));
         check(en10Modules, !(i[2] && i[1]));
      end
      wrReg(addrExt2, 16'h0000);
   endtask
   task automatic runNegotiate;
      logic [3:0] pa [7];
      logic [1:0] md [7];
      pa = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h8, 4'hF, 4'h0};
      md = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
      wrReg(addrCtrl, 16'h1000);
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         partnerAbility <= pa[i];
         waitc(5);
         check({speed100, fullDuplex}, md[i]);
      end
      wrReg(addrCtrl, 16'h2100);
      waitc(3);
      check({speed100, fullDuplex}, 2'h3);
   endtask
   task automatic runDuplex;
      logic s;
      logic f;
      for (int i = 0; i < 4; i++) begin
         s = i[1];
         f = i[0];
         wrReg(addrCtrl, {2'h0, s, 4'h0, f, 8'h00});
         waitc(3);
         traffic(1'b1, 1'b0);
         check({macCrs, macRxDv}, {!f, 1'b0});
         if (!s) check((tx10Code ^ (tx10Code >> 1)) & 8'h55, 8'h55);
         if (!s) check(tx100Code, 5'h00);
         if (s) check(tx10Code, 8'h00);
         if (!s) check(tpTxOut[1] ^ tpTxOut[0], 1'b1);
         if (s || f) check(macRxData, 4'h0);
         traffic(1'b1, 1'b1);
         check({macCrs, macCol}, {1'b1, !f});
         if (f) check(macRxDv, 1'b1);
         traffic(1'b0, 1'b1);
         if (f) check({macCrs, macCol}, 2'h2);
         traffic(1'b1, 1'b0);
         traffic(1'b0, 1'b0);
         check(macCol, !s && !f);
         waitc(60);
      end
   endtask
   //////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      waitc(6);
      runDefaults();
      runBitPowerDown();
      runPinReset();
      runSave();
      runNegotiate();
      runDuplex();
      printVerdict();
   end
   initial begin
      repeat (5000) @(posedge clk);
      errTotal++;
      printVerdict();
   end
endmodule
